// *** verilog/led_display_register_bank.sv ***
// register bank and character decoder of a four-digit led display driver
// assumes scl/sda come from a two-wire master in another clock domain,
// slow enough (about 800 ns per bit) to be oversampled by core_clk_in
//
// How it works
// - writes to key registers 08, 0C discarded
// - digits drive a..g from D6..D0; 24 drives lines
// - raw bit one lights, zero extinguishes segment
// - decode register: one bit per digit, D0..D3
// - set bit uses hex font, clear bypasses
// - decoder uses only low nibble D3..D0
// - undecoded digit bits map straight onto segments
// - hex font table for nibbles 0 to F
// - reset: shutdown, blank, config S and R zero
// - reset: four digits, no decode, brightness 4
// - reset: port register reads 10000xx0
// - reset: both key registers read zero
// - reset: digit and segment registers cleared
// - first byte after write address is command
// - pointer advances per data byte, sticks at 7F
`timescale 1ns/1ps
module led_display_register_bank
  import led_regs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n_out,
  output logic [6:0] digit0_seg_out,
  output logic [6:0] digit1_seg_out,
  output logic [6:0] digit2_seg_out,
  output logic [6:0] digit3_seg_out,
  output logic [7:0] discrete_seg_out,
  output logic shutdown_out,
  output logic [5:0] brightness_out,
  output logic [1:0] scan_limit_out,
  output logic lamp_test_out
);

  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
    link_state_t state;
    logic [2:0] bit_cnt;
    logic byte_done;
    logic [7:0] shift;
    logic rw;
    logic cmd_phase;
    logic master_ack;
    logic sda_drive_n;
    logic [7:0] ptr;
    logic [3:0] decode;
    logic [5:0] bright;
    logic [1:0] scan;
    logic shutdown;
    logic [7:0] port_ctl;
    logic lamp;
    logic [NUM_DIGITS-1:0][6:0] digit;
    logic [7:0] segs;
    logic [NUM_DIGITS-1:0][6:0] seg_q;
    logic [7:0] disc_q;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;
  logic [NUM_DIGITS-1:0][6:0] font_seg;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic rx_data_done;
  logic [7:0] next_ptr;
  logic [7:0] rd_byte;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIGITS; gi++) begin : g_font
      hex_font u_font (
        .nibble_in(s_q.digit[gi][3:0]),
        .seg_out(font_seg[gi])
      );
    end
  endgenerate

  assign scl_rise = s_q.scl_sync && !s_q.scl_prev;
  assign scl_fall = !s_q.scl_sync && s_q.scl_prev;
  // sda edges only count as start/stop while the clock line stays high
  assign start_seen = s_q.scl_sync && s_q.scl_prev && s_q.sda_prev && !s_q.sda_sync;
  assign stop_seen = s_q.scl_sync && s_q.scl_prev && !s_q.sda_prev && s_q.sda_sync;
  assign rx_data_done = scl_fall && (s_q.state == ST_RX) && s_q.byte_done &&
                        !s_q.cmd_phase;
  assign next_ptr = (s_q.ptr == ADDR_PTR_TOP) ? s_q.ptr : 8'(s_q.ptr + 8'h01);

  always_comb begin
    unique case (s_q.ptr)
      ADDR_DECODE: rd_byte = {4'h0, s_q.decode};
      ADDR_BRIGHT: rd_byte = {2'h0, s_q.bright};
      ADDR_SCAN: rd_byte = {6'h00, s_q.scan};
      // global-clear bit is transient and always reads zero
      ADDR_CONFIG: rd_byte = {6'h00, DEV_TYPE_BIT, !s_q.shutdown};
      ADDR_PORT: rd_byte = s_q.port_ctl;
      ADDR_TEST: rd_byte = {7'h00, s_q.lamp};
      ADDR_KEY_DEB: rd_byte = KEYS_RST;
      ADDR_KEY_PRS: rd_byte = KEYS_RST;
      ADDR_DIGIT0: rd_byte = {1'h0, s_q.digit[0]};
      ADDR_DIGIT1: rd_byte = {1'h0, s_q.digit[1]};
      ADDR_DIGIT2: rd_byte = {1'h0, s_q.digit[2]};
      ADDR_DIGIT3: rd_byte = {1'h0, s_q.digit[3]};
      ADDR_SEGS: rd_byte = s_q.segs;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers for the link lines
    s_d.scl_meta = scl_in;
    s_d.scl_sync = s_q.scl_meta;
    s_d.scl_prev = s_q.scl_sync;
    s_d.sda_meta = sda_in;
    s_d.sda_sync = s_q.sda_meta;
    s_d.sda_prev = s_q.sda_sync;

    // display path, registered so outputs come from flops
    for (int i = 0; i < NUM_DIGITS; i++) begin
      s_d.seg_q[i] = s_q.decode[i] ? font_seg[i] : s_q.digit[i];
    end
    s_d.disc_q = s_q.segs;

    if (start_seen) begin
      s_d.state = ST_ADDR;
      s_d.bit_cnt = 3'h0;
      s_d.byte_done = 1'b0;
      s_d.sda_drive_n = 1'b1;
    end else if (stop_seen) begin
      s_d.state = ST_IDLE;
      s_d.sda_drive_n = 1'b1;
    end else if (scl_rise) begin
      unique case (s_q.state)
        ST_ADDR, ST_RX: begin
          s_d.shift = {s_q.shift[6:0], s_q.sda_sync};
          s_d.bit_cnt = 3'(s_q.bit_cnt + 3'h1);
          s_d.byte_done = (s_q.bit_cnt == 3'h7);
        end
        ST_TX: begin
          s_d.bit_cnt = 3'(s_q.bit_cnt + 3'h1);
          s_d.byte_done = (s_q.bit_cnt == 3'h7);
        end
        ST_ACK_IN: s_d.master_ack = !s_q.sda_sync;
        ST_IDLE, ST_ACK_OUT: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (s_q.state)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (s_q.byte_done) begin
            s_d.byte_done = 1'b0;
            if (s_q.shift[7:1] == DEV_ADDR) begin
              s_d.rw = s_q.shift[0];
              s_d.cmd_phase = !s_q.shift[0];
              s_d.sda_drive_n = 1'b0;
              s_d.state = ST_ACK_OUT;
            end else begin
              s_d.state = ST_IDLE;
            end
          end
        end
        ST_RX: begin
          if (s_q.byte_done) begin
            s_d.byte_done = 1'b0;
            s_d.sda_drive_n = 1'b0;
            s_d.state = ST_ACK_OUT;
            if (s_q.cmd_phase) begin
              s_d.ptr = s_q.shift;
              s_d.cmd_phase = 1'b0;
            end else begin
              s_d.ptr = next_ptr;
              // no_operation, factory, key and unmapped addresses fall to default
              unique case (s_q.ptr)
                ADDR_DECODE: s_d.decode = s_q.shift[3:0];
                ADDR_BRIGHT: s_d.bright = s_q.shift[5:0];
                ADDR_SCAN: s_d.scan = s_q.shift[1:0];
                ADDR_CONFIG: begin
                  s_d.shutdown = !s_q.shift[CFG_S_BIT];
                  if (s_q.shift[CFG_R_BIT]) begin
                    s_d.digit = '0;
                    s_d.segs = SEGS_RST;
                  end
                end
                ADDR_PORT: s_d.port_ctl = s_q.shift;
                ADDR_TEST: s_d.lamp = s_q.shift[0];
                ADDR_DIGIT0: s_d.digit[0] = s_q.shift[6:0];
                ADDR_DIGIT1: s_d.digit[1] = s_q.shift[6:0];
                ADDR_DIGIT2: s_d.digit[2] = s_q.shift[6:0];
                ADDR_DIGIT3: s_d.digit[3] = s_q.shift[6:0];
                ADDR_SEGS: s_d.segs = s_q.shift;
                default: begin
                end
              endcase
            end
          end
        end
        ST_ACK_OUT: begin
          s_d.sda_drive_n = 1'b1;
          s_d.bit_cnt = 3'h0;
          s_d.byte_done = 1'b0;
          if (s_q.rw) begin
            s_d.shift = rd_byte;
            s_d.sda_drive_n = rd_byte[7];
            s_d.ptr = next_ptr;
            s_d.state = ST_TX;
          end else begin
            s_d.state = ST_RX;
          end
        end
        ST_TX: begin
          if (s_q.byte_done) begin
            s_d.byte_done = 1'b0;
            s_d.sda_drive_n = 1'b1;
            s_d.state = ST_ACK_IN;
          end else begin
            s_d.shift = {s_q.shift[6:0], 1'b0};
            s_d.sda_drive_n = s_q.shift[6];
          end
        end
        ST_ACK_IN: begin
          // a not-acknowledge ends the read; stop follows
          if (s_q.master_ack) begin
            s_d.shift = rd_byte;
            s_d.sda_drive_n = rd_byte[7];
            s_d.ptr = next_ptr;
            s_d.bit_cnt = 3'h0;
            s_d.state = ST_TX;
          end else begin
            s_d.state = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.scl_meta <= 1'b1;
      s_q.scl_sync <= 1'b1;
      s_q.scl_prev <= 1'b1;
      s_q.sda_meta <= 1'b1;
      s_q.sda_sync <= 1'b1;
      s_q.sda_prev <= 1'b1;
      s_q.state <= ST_IDLE;
      s_q.sda_drive_n <= 1'b1;
      s_q.decode <= DECODE_RST;
      s_q.bright <= BRIGHT_RST;
      s_q.scan <= SCAN_RST;
      s_q.shutdown <= SHUTDOWN_RST;
      s_q.port_ctl <= PORT_RST;
      s_q.digit <= {NUM_DIGITS{DIGIT_RST}};
      s_q.segs <= SEGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_out = 1'b0 & s_q.sda_prev;
  assign sda_drive_n_out = s_q.sda_drive_n;
  assign digit0_seg_out = s_q.seg_q[0];
  assign digit1_seg_out = s_q.seg_q[1];
  assign digit2_seg_out = s_q.seg_q[2];
  assign digit3_seg_out = s_q.seg_q[3];
  assign discrete_seg_out = s_q.disc_q;
  assign shutdown_out = s_q.shutdown;
  assign brightness_out = s_q.bright;
  assign scan_limit_out = s_q.scan;
  assign lamp_test_out = s_q.lamp;

  default clocking dflt_cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  raw_digit_map_a: assert property (
    !s_q.decode[0] |=> digit0_seg_out == $past(s_q.digit[0]))
    else $error("raw digit 0 does not follow its register");
  hex_zero_font_a: assert property (
    s_q.decode[1] && s_q.digit[1][3:0] == 4'h0 |=> digit1_seg_out == 7'h7E)
    else $error("hex zero font wrong on digit 1");
  hex_high_bits_a: assert property (
    s_q.decode[2] && s_q.digit[2][3:0] == 4'hB |=> digit2_seg_out == 7'h1F)
    else $error("hex decode looks at bits above the nibble");
  discrete_map_a: assert property (
    ##1 discrete_seg_out == $past(s_q.segs))
    else $error("discrete lines do not follow segment register");
  ptr_stick_a: assert property (
    rx_data_done && s_q.ptr == ADDR_PTR_TOP |=> s_q.ptr == ADDR_PTR_TOP)
    else $error("pointer moved past top address");
  ptr_advance_a: assert property (
    rx_data_done && s_q.ptr != ADDR_PTR_TOP |=> s_q.ptr == 8'($past(s_q.ptr) + 8'h01))
    else $error("pointer did not advance after data byte");
  ignored_write_a: assert property (
    rx_data_done && (s_q.ptr == ADDR_KEY_DEB || s_q.ptr == ADDR_KEY_PRS ||
    s_q.ptr == ADDR_NOOP || s_q.ptr == 8'h30) |=>
    $stable(s_q.digit) && $stable(s_q.segs) && $stable(s_q.decode) && $stable(s_q.shutdown))
    else $error("ignored address changed a register");
  global_clear_a: assert property (
    rx_data_done && s_q.ptr == ADDR_CONFIG && s_q.shift[CFG_R_BIT] |=>
    s_q.digit == '0 && s_q.segs == SEGS_RST ##1 discrete_seg_out == SEGS_RST)
    else $error("global clear left digit data");
  addr_ack_a: assert property (
    scl_fall && s_q.state == ST_ADDR && s_q.byte_done && s_q.shift[7:1] == DEV_ADDR
    && !start_seen && !stop_seen |=> !sda_drive_n_out && s_q.state == ST_ACK_OUT)
    else $error("matching address not acknowledged");
  cmd_load_a: assert property (
    scl_fall && s_q.state == ST_RX && s_q.byte_done && s_q.cmd_phase |=>
    s_q.ptr == $past(s_q.shift))
    else $error("command byte did not load the pointer");
  read_ptr_a: assert property (
    scl_fall && s_q.state == ST_ACK_IN && s_q.master_ack && s_q.ptr != ADDR_PTR_TOP |=>
    s_q.ptr == 8'($past(s_q.ptr) + 8'h01))
    else $error("pointer did not advance after read byte");
  shutdown_bit_a: assert property (
    rx_data_done && s_q.ptr == ADDR_CONFIG |=> shutdown_out == !$past(s_q.shift[CFG_S_BIT]))
    else $error("shutdown output does not follow control write");
  key_write_a: assert property (
    rx_data_done && (s_q.ptr == ADDR_KEY_DEB || s_q.ptr == ADDR_KEY_PRS) |=>
    $stable(s_q.port_ctl) && $stable(s_q.bright) && $stable(s_q.scan) && $stable(s_q.lamp))
    else $error("write to a key register changed a setting");

  write_digit_c: cover property (rx_data_done && s_q.ptr == ADDR_DIGIT0);
  read_byte_c: cover property (s_q.state == ST_ACK_IN ##[1:40] s_q.state == ST_TX);
  decode_on_c: cover property (s_q.decode == 4'hF);
  ptr_top_c: cover property (rx_data_done && s_q.ptr == ADDR_PTR_TOP);
  clear_c: cover property (rx_data_done && s_q.ptr == ADDR_CONFIG && s_q.shift[CFG_R_BIT]);
endmodule : led_display_register_bank

// *** verilog/led_regs_pkg.sv ***
// constants for the four-digit led display register bank
// assumes a 10 MHz core clock and a two-wire serial master outside
package led_regs_pkg;
  // seven-bit bus address of the device on the two-wire link
  localparam logic [6:0] DEV_ADDR = 7'h38;
  // device-type readback bit in the control register (value arbitrary)
  localparam logic DEV_TYPE_BIT = 1'h0;

  localparam logic [7:0] ADDR_NOOP = 8'h00;
  localparam logic [7:0] ADDR_DECODE = 8'h01;
  localparam logic [7:0] ADDR_BRIGHT = 8'h02;
  localparam logic [7:0] ADDR_SCAN = 8'h03;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_FACTORY = 8'h05;
  localparam logic [7:0] ADDR_PORT = 8'h06;
  localparam logic [7:0] ADDR_TEST = 8'h07;
  localparam logic [7:0] ADDR_KEY_DEB = 8'h08;
  localparam logic [7:0] ADDR_KEY_PRS = 8'h0C;
  localparam logic [7:0] ADDR_DIGIT0 = 8'h20;
  localparam logic [7:0] ADDR_DIGIT1 = 8'h21;
  localparam logic [7:0] ADDR_DIGIT2 = 8'h22;
  localparam logic [7:0] ADDR_DIGIT3 = 8'h23;
  localparam logic [7:0] ADDR_SEGS = 8'h24;
  localparam logic [7:0] ADDR_PTR_TOP = 8'h7F;

  // control register field positions
  localparam int CFG_S_BIT = 0;
  localparam int CFG_D_BIT = 1;
  localparam int CFG_R_BIT = 5;

  // values after reset
  localparam logic [3:0] DECODE_RST = 4'h0;
  localparam logic [5:0] BRIGHT_RST = 6'h04;
  localparam logic [1:0] SCAN_RST = 2'h3;
  localparam logic SHUTDOWN_RST = 1'h1;
  localparam logic [7:0] PORT_RST = 8'h80;
  localparam logic [7:0] KEYS_RST = 8'h00;
  localparam logic [6:0] DIGIT_RST = 7'h00;
  localparam logic [7:0] SEGS_RST = 8'h00;

  localparam int NUM_DIGITS = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_RX,
    ST_ACK_OUT,
    ST_TX,
    ST_ACK_IN
  } link_state_t;
endpackage : led_regs_pkg

// *** verilog/hex_font.sv ***
// hexadecimal seven-segment font, segments a..g on bits 6..0
// assumes a purely combinational use; the caller registers the result
`timescale 1ns/1ps
module hex_font (
  input wire logic [3:0] nibble_in,
  output logic [6:0] seg_out
);
  always_comb begin
    unique case (nibble_in)
      4'h0: seg_out = 7'h7E;
      4'h1: seg_out = 7'h30;
      4'h2: seg_out = 7'h6D;
      4'h3: seg_out = 7'h79;
      4'h4: seg_out = 7'h33;
      4'h5: seg_out = 7'h5B;
      4'h6: seg_out = 7'h5F;
      4'h7: seg_out = 7'h70;
      4'h8: seg_out = 7'h7F;
      4'h9: seg_out = 7'h7B;
      4'hA: seg_out = 7'h77;
      4'hB: seg_out = 7'h1F;
      4'hC: seg_out = 7'h4E;
      4'hD: seg_out = 7'h3D;
      4'hE: seg_out = 7'h4F;
      4'hF: seg_out = 7'h47;
    endcase
  end
endmodule : hex_font

// *** testbench/two_wire_master.sv ***
// two-wire bus master model for the led display register bank
// assumes pullups on scl and sda; the bench ands every sda driver
`timescale 1ns/1ps
module two_wire_master (
  input wire logic core_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // scl stands high between frames; 8 core clocks a bit gives 800 ns
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : tick
  // also a repeated start when entered with scl low
  task automatic start_cond();
    sda_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    sda_out <= 1'b0;
    tick(2);
    scl_out <= 1'b0;
    tick(2);
  endtask : start_cond
  task automatic stop_cond();
    sda_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    sda_out <= 1'b1;
    tick(2);
  endtask : stop_cond
  // sda held through the whole high phase, sampled in its middle
  task automatic clock_bit(input logic b, output logic seen);
    sda_out <= b;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    seen = sda_in;
    tick(2);
    scl_out <= 1'b0;
    tick(2);
  endtask : clock_bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, ack);
  endtask : put_byte
  // nack only after the last byte of a read
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(last, s);
  endtask : get_byte
endmodule : two_wire_master

// *** testbench/testbench.sv ***
// self-checking bench for the led display register bank
// assumes the two-wire master model; sda is a wired-and of all drivers
`timescale 1ns/1ps
module testbench
  import led_regs_pkg::*;
;
  localparam int LIMIT = 60000;
  localparam logic [6:0] FONT [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70,
    7'h7F, 7'h7B, 7'h77, 7'h1F, 7'h4E, 7'h3D, 7'h4F, 7'h47};
  // no burst from these starts reaches the factory address
  localparam logic [7:0] STARTS [8] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h0B, 8'h1E, 8'h20, 8'h22};
  logic core_clk_in, resetn_in, scl, m_sda, sda_dev, drive_n, shutdown, lamp;
  logic [6:0] d0, d1, d2, d3;
  logic [7:0] discrete;
  logic [5:0] bright;
  logic [1:0] scan;
  logic [7:0] regs [0:127];
  logic [7:0] wbuf [0:3];
  logic [7:0] rd [0:35];
  int num_errors = 0, samples_checked = 0, seed = 8283, cycles = 0;
  wire logic sda_wire = m_sda & (drive_n | sda_dev);

  led_display_register_bank u_led_display_register_bank (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_dev),
    .sda_drive_n_out(drive_n), .digit0_seg_out(d0), .digit1_seg_out(d1), .digit2_seg_out(d2),
    .digit3_seg_out(d3), .discrete_seg_out(discrete), .shutdown_out(shutdown),
    .brightness_out(bright), .scan_limit_out(scan), .lamp_test_out(lamp));
  two_wire_master u_two_wire_master (.core_clk_in(core_clk_in), .sda_in(sda_wire),
    .scl_out(scl), .sda_out(m_sda));

  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check8(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check8
  // readback bits compared; the rest are left open
  function automatic logic [7:0] rd_mask(input int a);
    case (a)
      ADDR_CONFIG: return 8'h03;
      ADDR_TEST: return 8'h01;
      ADDR_DECODE, ADDR_BRIGHT, ADDR_SCAN, ADDR_PORT, ADDR_KEY_DEB, ADDR_KEY_PRS: return 8'hFF;
      ADDR_DIGIT0, ADDR_DIGIT1, ADDR_DIGIT2, ADDR_DIGIT3, ADDR_SEGS: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction : rd_mask
  task automatic apply_write(input logic [7:0] a, input logic [7:0] d);
    case (a)
      ADDR_DECODE: regs[a] = {4'h0, d[3:0]};
      ADDR_BRIGHT: regs[a] = {2'h0, d[5:0]};
      ADDR_SCAN: regs[a] = {6'h00, d[1:0]};
      ADDR_CONFIG: begin
        regs[a] = {6'h00, DEV_TYPE_BIT, d[CFG_S_BIT]};
        if (d[CFG_R_BIT]) for (int i = 32; i < 37; i++) regs[i] = 8'h00;
      end
      ADDR_PORT, ADDR_TEST, ADDR_SEGS: regs[a] = d;
      ADDR_DIGIT0, ADDR_DIGIT1, ADDR_DIGIT2, ADDR_DIGIT3: regs[a] = {1'b0, d[6:0]};
      default: ;
    endcase
  endtask : apply_write
  task automatic write_regs(input logic [7:0] a, input int n);
    logic ack;
    u_two_wire_master.start_cond();
    u_two_wire_master.put_byte({DEV_ADDR, 1'b0}, ack);
    check8({7'h00, ack}, 8'h00);
    u_two_wire_master.put_byte(a, ack);
    for (int i = 0; i < n; i++) begin
      u_two_wire_master.put_byte(wbuf[i], ack);
      check8({7'h00, ack}, 8'h00);
      apply_write(a, wbuf[i]);
      a = (a == ADDR_PTR_TOP) ? a : a + 8'h01;
    end
    u_two_wire_master.stop_cond();
  endtask : write_regs
  task automatic check_regs();
    logic ack;
    u_two_wire_master.start_cond();
    u_two_wire_master.put_byte({DEV_ADDR, 1'b0}, ack);
    u_two_wire_master.put_byte(ADDR_DECODE, ack);
    u_two_wire_master.start_cond();
    u_two_wire_master.put_byte({DEV_ADDR, 1'b1}, ack);
    for (int i = 0; i < 36; i++) u_two_wire_master.get_byte(i == 35, rd[i]);
    u_two_wire_master.stop_cond();
    for (int i = 0; i < 36; i++) check8(rd[i] & rd_mask(i + 1), regs[i + 1] & rd_mask(i + 1));
  endtask : check_regs
  task automatic check_outs();
    logic [27:0] all;
    logic [7:0] d;
    logic [6:0] e;
    all = {d3, d2, d1, d0};
    for (int n = 0; n < 4; n++) begin
      d = regs[ADDR_DIGIT0 + n];
      e = regs[ADDR_DECODE][n] ? FONT[d[3:0]] : d[6:0];
      check8({1'b0, all[n * 7 +: 7]}, {1'b0, e});
    end
    check8(discrete, regs[ADDR_SEGS]);
    check8({7'h00, shutdown}, {7'h00, ~regs[ADDR_CONFIG][0]});
    check8({2'h0, bright}, regs[ADDR_BRIGHT]);
    check8({6'h00, scan}, regs[ADDR_SCAN]);
    check8({7'h00, lamp}, {7'h00, regs[ADDR_TEST][0]});
  endtask : check_outs
  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    foreach (regs[i]) regs[i] = 8'h00;
    regs[ADDR_BRIGHT] = 8'h04;
    regs[ADDR_SCAN] = 8'h03;
    regs[ADDR_PORT] = 8'h80;
    check_outs();
    check_regs();
  endtask : do_reset

  initial begin
    logic ack;
    logic [7:0] a;
    int n;
    resetn_in = 1'b0;
    do_reset();
    // a foreign device address gets no ack and the bytes after it are ignored
    u_two_wire_master.start_cond();
    u_two_wire_master.put_byte({DEV_ADDR ^ 7'h01, 1'b0}, ack);
    check8({7'h00, ack}, 8'h01);
    u_two_wire_master.put_byte(ADDR_SEGS, ack);
    u_two_wire_master.put_byte(8'hFF, ack);
    u_two_wire_master.stop_cond();
    check_outs();
    // every nibble through the font, upper bits set to show they are ignored
    wbuf = '{8'hFF, 8'h00, 8'h00, 8'h00};
    write_regs(ADDR_DECODE, 1);
    // rotated so that each digit sees all sixteen nibbles
    for (int k = 0; k < 16; k++) begin
      for (int j = 0; j < 4; j++) wbuf[j] = 8'hF0 | 8'((k + j) % 16);
      write_regs(ADDR_DIGIT0, 4);
      check_outs();
    end
    // unmapped address, then a burst that must stick at the pointer top
    wbuf = '{8'h7F, 8'h7F, 8'h00, 8'h00};
    write_regs(8'h30, 1);
    write_regs(ADDR_PTR_TOP, 2);
    check_outs();
    for (int it = 0; it < 30; it++) begin
      a = STARTS[$unsigned($random(seed)) % 8];
      n = (a == ADDR_CONFIG) ? 1 : 1 + $unsigned($random(seed)) % 3;
      foreach (wbuf[j]) wbuf[j] = 8'($random(seed));
      write_regs(a, n);
      check_outs();
      if (it % 6 == 5) check_regs();
    end
    do_reset();
    complete_run();
  end
endmodule : testbench
